// file: sapsy_pkg.sv
// constants and types shared by the special register access block.
// assumes a single core clock domain; register numbers are move-to/from numbers.
package sapsy_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int SPR_NUM_W  = 10;
  localparam int SPR_DATA_W = 32;

  // ----------------------------------------------------------------
  // implemented register numbers
  // ----------------------------------------------------------------
  localparam logic [SPR_NUM_W-1:0] SPR_CRIT_SAVE_0     = 10'h03a;
  localparam logic [SPR_NUM_W-1:0] SPR_CRIT_SAVE_1     = 10'h03b;
  localparam logic [SPR_NUM_W-1:0] SPR_BRANCH_UNIT     = 10'h3f5;
  localparam logic [SPR_NUM_W-1:0] SPR_CONTEXT_CONTROL = 10'h230;

  // privilege bit of a register number: bit 5 of the instruction field,
  // counted from the msb of the swapped halves, is bit 4 of the number
  localparam int SPR_PRIV_BIT = 4;

  // ----------------------------------------------------------------
  // context control register layout
  // ----------------------------------------------------------------
  localparam int CTX_FIELD_W     = 4;
  localparam int CTX_COUNT_LSB   = 0;
  localparam int CTX_CURRENT_LSB = 8;
  localparam int CTX_ALT_LSB     = 16;
  localparam int CTX_SAVED_LSB   = 24;
  localparam int CTX_COUNT_MAX   = 15;
  localparam logic [SPR_DATA_W-1:0] CTX_WRITE_MASK = 32'h0f0f_0f00;
  localparam logic [SPR_DATA_W-1:0] SPR_RESET      = 32'h0000_0000;

  // ----------------------------------------------------------------
  // context synchronising operations, one bit each
  // ----------------------------------------------------------------
  localparam int CSI_KINDS = 5;
  localparam int CSI_SYSCALL = 0;
  localparam int CSI_ISYNC   = 1;
  localparam int CSI_RFI     = 2;
  localparam int CSI_RFCI    = 3;
  localparam int CSI_RFDI    = 4;

  // number of save/restore registers handled by one loop
  localparam int SAVE_REGS = 2;

  // exception answer of one access
  typedef enum logic [1:0] {
    SAPSY_EXC_NONE    = 2'h0,
    SAPSY_EXC_ILLEGAL = 2'h1,
    SAPSY_EXC_PRIV    = 2'h2
  } sapsy_exc_t;

endpackage

// file: sapsy_spr_access.sv
// special register access unit: move-to/move-from decode, exceptions,
// save/restore and branch unit registers, context control register.
// assumes requests come from the core pipeline on mclk, one per cycle at most.
//
// Operation
// - context control is 32-bit, supervisor only
// - context register holds current, alternate, saved contexts
// - writes accepted only when context count nonzero
// - no extra contexts: writes dropped, reads zero
// - this build has zero contexts by default
// - invalid number: privilege taken from bit 5
// - bit 5 clear: always illegal exception
// - bit 5 set, supervisor: illegal exception
// - bit 5 set, user mode: privilege exception
// - access only through move-to/move-from requests
// - all registers 32 bits, msb first
// - syscall, isync, returns are context synchronising
`timescale 1ns/1ps
module sapsy_spr_access #(
  parameter int CTX_COUNT = 0
) (
  input  wire logic                             mclk,
  input  wire logic                             rstn,
  input  wire logic                             spr_valid,
  input  wire logic                             spr_write,
  input  wire logic [sapsy_pkg::SPR_NUM_W-1:0]  spr_num,
  input  wire logic [sapsy_pkg::SPR_DATA_W-1:0] spr_wdata,
  input  wire logic                             user_mode_flag,
  input  wire logic                             user_cache_lock_enable_change,
  input  wire logic [sapsy_pkg::CSI_KINDS-1:0]  csi_event,
  output logic                                  spr_done,
  output logic      [sapsy_pkg::SPR_DATA_W-1:0] spr_rdata,
  output logic                                  illegal_exc,
  output logic                                  priv_exc,
  output logic      [sapsy_pkg::SPR_DATA_W-1:0] branch_unit_ctrl_status,
  output logic      [sapsy_pkg::CTX_FIELD_W-1:0] ctx_current,
  output logic                                  csi_pending
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  // a count wider than its field would read back as fewer contexts
  if (CTX_COUNT < 0 || CTX_COUNT > sapsy_pkg::CTX_COUNT_MAX) begin : g_bad_count
    $error("context count does not fit its field");
  end

  localparam logic [sapsy_pkg::CTX_FIELD_W-1:0] COUNT_VAL =
    sapsy_pkg::CTX_FIELD_W'(CTX_COUNT);
  localparam logic CTX_PRESENT = (CTX_COUNT != 0);

  logic [sapsy_pkg::SAVE_REGS-1:0]  hit_save;
  logic                             hit_branch;
  logic                             hit_context;
  sapsy_pkg::sapsy_exc_t            exc;
  logic                             ok_access;
  logic                             ok_write;
  logic                             ok_read;
  logic [sapsy_pkg::SPR_DATA_W-1:0] save_reg [sapsy_pkg::SAVE_REGS];
  logic [sapsy_pkg::SPR_DATA_W-1:0] context_control_reg;
  logic [sapsy_pkg::SPR_DATA_W-1:0] context_view;
  logic [sapsy_pkg::SPR_DATA_W-1:0] next_rdata;
  logic                             need_csi;

  // ----------------------------------------------------------------
  // decode and sync tracking
  // ----------------------------------------------------------------
  sapsy_spr_decode u_decode (
    .spr_num        (spr_num),
    .user_mode_flag (user_mode_flag),
    .hit_save       (hit_save),
    .hit_branch     (hit_branch),
    .hit_context    (hit_context),
    .exc            (exc)
  );

  // the block only reports the owed sync; stalling the core is not its job
  sapsy_sync_track u_sync (
    .mclk        (mclk),
    .rstn        (rstn),
    .need_csi    (need_csi),
    .csi_event   (csi_event),
    .csi_pending (csi_pending)
  );

  // branch unit and context control writes, and a lock enable change,
  // leave software owing a synchronising operation afterwards
  assign need_csi = (ok_write & (hit_branch | hit_context)) | user_cache_lock_enable_change;

  // ----------------------------------------------------------------
  // access qualification: nothing moves except through a request
  // ----------------------------------------------------------------
  assign ok_access = spr_valid & (exc == sapsy_pkg::SAPSY_EXC_NONE);
  assign ok_write  = ok_access & spr_write;
  assign ok_read   = ok_access & ~spr_write;

  // ----------------------------------------------------------------
  // answer: done and exception flags one cycle after the request
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      spr_done    <= 1'b0;
      illegal_exc <= 1'b0;
      priv_exc    <= 1'b0;
    end else begin
      spr_done    <= spr_valid;
      illegal_exc <= spr_valid & (exc == sapsy_pkg::SAPSY_EXC_ILLEGAL);
      priv_exc    <= spr_valid & (exc == sapsy_pkg::SAPSY_EXC_PRIV);
    end
  end

  // ----------------------------------------------------------------
  // save/restore registers, one loop entry each
  // ----------------------------------------------------------------
  for (genvar i = 0; i < sapsy_pkg::SAVE_REGS; i++) begin : g_save
    always_ff @(posedge mclk) begin
      if (!rstn) begin
        save_reg[i] <= sapsy_pkg::SPR_RESET;
      end else if (ok_write && hit_save[i]) begin
        save_reg[i] <= spr_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // branch unit control register, drives the branch unit directly
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      branch_unit_ctrl_status <= sapsy_pkg::SPR_RESET;
    end else if (ok_write && hit_branch) begin
      branch_unit_ctrl_status <= spr_wdata;
    end
  end

  // ----------------------------------------------------------------
  // context control register; with no contexts it stays all zero
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      context_control_reg <= sapsy_pkg::SPR_RESET;
    end else if (ok_write && hit_context && CTX_PRESENT) begin
      context_control_reg <= spr_wdata & sapsy_pkg::CTX_WRITE_MASK;
    end
  end

  // count field is fixed by the build; the rest only shows when present
  always_comb begin
    context_view = sapsy_pkg::SPR_RESET;
    if (CTX_PRESENT) begin
      context_view = context_control_reg;
      context_view[sapsy_pkg::CTX_COUNT_LSB +: sapsy_pkg::CTX_FIELD_W] = COUNT_VAL;
    end
  end

  // current context selects the mapped register bank
  assign ctx_current =
    context_view[sapsy_pkg::CTX_CURRENT_LSB +: sapsy_pkg::CTX_FIELD_W];

  // ----------------------------------------------------------------
  // read data: held until the next successful read
  // ----------------------------------------------------------------
  always_comb begin
    next_rdata = spr_rdata;
    if (ok_read) begin
      if (hit_save[0]) begin
        next_rdata = save_reg[0];
      end else if (hit_save[1]) begin
        next_rdata = save_reg[1];
      end else if (hit_branch) begin
        next_rdata = branch_unit_ctrl_status;
      end else begin
        next_rdata = context_view;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      spr_rdata <= sapsy_pkg::SPR_RESET;
    end else begin
      spr_rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  // one clock domain, so one default clocking and reset serve every check
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  // ----------------------------------------------------------------
  // answer timing and idle behaviour
  // ----------------------------------------------------------------

  a_done_follows: assert property (spr_valid |=> spr_done)
    else $error("request not answered in one cycle");

  a_quiet_idle: assert property (
    !spr_valid |=> !spr_done && !illegal_exc && !priv_exc)
    else $error("answer without a request");

  a_rdata_hold: assert property (!ok_read |=> $stable(spr_rdata))
    else $error("read data moved without a good read");

  // ----------------------------------------------------------------
  // exception decode, judged on the number bit and the mode flag
  // ----------------------------------------------------------------

  a_bit5_clear: assert property (
    spr_valid && !hit_context && !hit_branch && hit_save == '0
    && !spr_num[sapsy_pkg::SPR_PRIV_BIT] |=> illegal_exc && !priv_exc)
    else $error("invalid user number did not give illegal");

  a_super_illegal: assert property (
    spr_valid && exc != sapsy_pkg::SAPSY_EXC_NONE && !user_mode_flag
    |=> illegal_exc)
    else $error("supervisor invalid number did not give illegal");

  a_user_priv: assert property (
    spr_valid && user_mode_flag && spr_num[sapsy_pkg::SPR_PRIV_BIT]
    |=> priv_exc && !illegal_exc)
    else $error("user access to privileged number not refused");

  // ----------------------------------------------------------------
  // context control register
  // ----------------------------------------------------------------

  a_ctx_user: assert property (
    spr_valid && hit_context && user_mode_flag |=> priv_exc)
    else $error("user reached context control register");

  a_ctx_readzero: assert property (
    !CTX_PRESENT && spr_valid && !spr_write && hit_context && !user_mode_flag
    |=> spr_rdata == sapsy_pkg::SPR_RESET)
    else $error("context control read not zero");

  a_ctx_ignored: assert property (
    !CTX_PRESENT |-> context_control_reg == sapsy_pkg::SPR_RESET ##1
    ctx_current == '0)
    else $error("context control took a write without contexts");

  a_ctx_quiet: assert property (
    !CTX_PRESENT && spr_valid && spr_write && hit_context && !user_mode_flag
    |=> !illegal_exc && !priv_exc)
    else $error("dropped context write raised an exception");

  // ----------------------------------------------------------------
  // stored registers
  // ----------------------------------------------------------------

  a_save_write: assert property (
    ok_write && hit_save[0] ##1 (spr_valid && !spr_write && hit_save[0]
    && !user_mode_flag) |=> spr_rdata == $past(spr_wdata, 2))
    else $error("save register read back wrong");

  a_branch_stable: assert property (
    !(ok_write && hit_branch) |=> $stable(branch_unit_ctrl_status))
    else $error("branch unit register changed without a write");

  a_save_hold: assert property (!(ok_write && hit_save[1]) |=> $stable(save_reg[1]))
    else $error("save register changed without a write");

  a_exc_exclusive: assert property (!(illegal_exc && priv_exc))
    else $error("two exceptions at once");

  // ----------------------------------------------------------------
  // sync tracking
  // ----------------------------------------------------------------
  // the flag is advisory; the core decides whether to stall on it

  a_csi_owed: assert property (
    ok_write && hit_branch |=> csi_pending ##1 (csi_pending || $past(|csi_event)))
    else $error("branch write did not leave a sync owed");

  a_csi_clear: assert property (
    |csi_event && !need_csi |=> !csi_pending)
    else $error("sync operation did not clear owed flag");

  a_user_cache_lock_enable_owed: assert property (user_cache_lock_enable_change |=> csi_pending)
    else $error("lock enable change did not leave a sync owed");

  a_ctx_owed: assert property (
    ok_write && hit_context |=> csi_pending)
    else $error("context write did not leave a sync owed");

  // ----------------------------------------------------------------
  // cover points
  // ----------------------------------------------------------------

  c_illegal: cover property (spr_valid ##1 illegal_exc);
  c_priv: cover property (spr_valid && user_mode_flag ##1 priv_exc);
  c_branch_rw: cover property (ok_write && hit_branch ##[1:4] ok_read && hit_branch);
  c_csi_cycle: cover property (csi_pending ##1 !csi_pending);
  c_ctx_write: cover property (ok_write && hit_context);

endmodule

// file: sapsy_spr_decode.sv
// register number decode and exception classification, purely combinational.
// assumes the number and mode flag are stable while the access is presented.
`timescale 1ns/1ps
module sapsy_spr_decode (
  input  wire logic [sapsy_pkg::SPR_NUM_W-1:0] spr_num,
  input  wire logic                            user_mode_flag,
  output logic      [sapsy_pkg::SAVE_REGS-1:0] hit_save,
  output logic                                 hit_branch,
  output logic                                 hit_context,
  output sapsy_pkg::sapsy_exc_t                exc
);

  logic known;

  // ----------------------------------------------------------------
  // address match
  // ----------------------------------------------------------------
  always_comb begin
    hit_save[0] = (spr_num == sapsy_pkg::SPR_CRIT_SAVE_0);
    hit_save[1] = (spr_num == sapsy_pkg::SPR_CRIT_SAVE_1);
    hit_branch  = (spr_num == sapsy_pkg::SPR_BRANCH_UNIT);
    hit_context = (spr_num == sapsy_pkg::SPR_CONTEXT_CONTROL);
    known       = (|hit_save) | hit_branch | hit_context;
  end

  // ----------------------------------------------------------------
  // response: every implemented register here is supervisor only
  // ----------------------------------------------------------------
  always_comb begin
    exc = sapsy_pkg::SAPSY_EXC_NONE;
    if (known) begin
      if (user_mode_flag) begin
        exc = sapsy_pkg::SAPSY_EXC_PRIV;
      end
    end else if (!spr_num[sapsy_pkg::SPR_PRIV_BIT]) begin
      exc = sapsy_pkg::SAPSY_EXC_ILLEGAL;
    end else if (user_mode_flag) begin
      exc = sapsy_pkg::SAPSY_EXC_PRIV;
    end else begin
      exc = sapsy_pkg::SAPSY_EXC_ILLEGAL;
    end
  end

endmodule

// file: sapsy_sync_track.sv
// tracks whether software still owes a context synchronising operation.
// assumes all inputs come from logic on mclk; pulses are one cycle wide.
`timescale 1ns/1ps
module sapsy_sync_track (
  input  wire logic                            mclk,
  input  wire logic                            rstn,
  input  wire logic                            need_csi,
  input  wire logic [sapsy_pkg::CSI_KINDS-1:0] csi_event,
  output logic                                 csi_pending
);

  // ----------------------------------------------------------------
  // pending flag; a new need in the clearing cycle wins, so it is not lost
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      csi_pending <= 1'b0;
    end else if (need_csi) begin
      csi_pending <= 1'b1;
    end else if (|csi_event) begin
      csi_pending <= 1'b0;
    end
  end

endmodule

// file: tb.sv
// self-checking testbench for the special register access unit.
// assumes the unit is built with no extra register contexts (default).
`timescale 1ns/1ps
module tb;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic                                 mclk;
  logic                                 rstn;
  logic                                 spr_valid;
  logic                                 spr_write;
  logic [sapsy_pkg::SPR_NUM_W-1:0]      spr_num;
  logic [sapsy_pkg::SPR_DATA_W-1:0]     spr_wdata;
  logic                                 user_mode_flag;
  logic                                 user_cache_lock_enable_change;
  logic [sapsy_pkg::CSI_KINDS-1:0]      csi_event;
  logic                                 spr_done;
  logic [sapsy_pkg::SPR_DATA_W-1:0]     spr_rdata;
  logic                                 illegal_exc;
  logic                                 priv_exc;
  logic [sapsy_pkg::SPR_DATA_W-1:0]     branch_unit_ctrl_status;
  logic [sapsy_pkg::CTX_FIELD_W-1:0]    ctx_current;
  logic                                 csi_pending;
  logic                                 got_ill;
  logic                                 got_priv;
  int                                   miscompares;
  int                                   n_tests;

  sapsy_spr_access i_dut (
    .mclk                    (mclk),
    .rstn                    (rstn),
    .spr_valid               (spr_valid),
    .spr_write               (spr_write),
    .spr_num                 (spr_num),
    .spr_wdata               (spr_wdata),
    .user_mode_flag          (user_mode_flag),
    .user_cache_lock_enable_change             (user_cache_lock_enable_change),
    .csi_event               (csi_event),
    .spr_done                (spr_done),
    .spr_rdata               (spr_rdata),
    .illegal_exc             (illegal_exc),
    .priv_exc                (priv_exc),
    .branch_unit_ctrl_status (branch_unit_ctrl_status),
    .ctx_current             (ctx_current),
    .csi_pending             (csi_pending)
  );

  // 125 MHz core clock
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // four-state compare so an unknown never passes
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // one move-to/move-from; done is bounded so a dead unit cannot hang the run
  task automatic acc(input logic wr, input logic [sapsy_pkg::SPR_NUM_W-1:0] num,
                     input logic [31:0] d, input logic usr);
    int n;
    n = 0;
    @(posedge mclk);
    spr_valid      <= 1'b1;
    spr_write      <= wr;
    spr_num        <= num;
    spr_wdata      <= d;
    user_mode_flag <= usr;
    @(posedge mclk);
    spr_valid <= 1'b0;
    #1;
    while (spr_done !== 1'b1 && n < 4) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (spr_done !== 1'b1) begin
      miscompares++;
      $display("wrong value at %0t: no done", $time);
      conclude();
    end
    got_ill  = illegal_exc;
    got_priv = priv_exc;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic sc_save_regs();
    acc(1'b1, sapsy_pkg::SPR_CRIT_SAVE_0, 32'h8000_0001, 1'b0);
    acc(1'b1, sapsy_pkg::SPR_CRIT_SAVE_1, 32'h7ffe_a5c3, 1'b0);
    chk(got_ill | got_priv, 1'b0, "save write exc");
    acc(1'b0, sapsy_pkg::SPR_CRIT_SAVE_0, 32'h0000_0000, 1'b0);
    chk(spr_rdata, 32'h8000_0001, "save 0 read");
    acc(1'b0, sapsy_pkg::SPR_CRIT_SAVE_1, 32'h0000_0000, 1'b0);
    chk(spr_rdata, 32'h7ffe_a5c3, "save 1 read");
    @(posedge mclk);
    #1;
    chk(spr_done, 1'b0, "done one cycle");
    // back to back write then read of the same register, no idle cycle
    @(posedge mclk);
    spr_valid      <= 1'b1;
    spr_write      <= 1'b1;
    spr_num        <= sapsy_pkg::SPR_CRIT_SAVE_0;
    spr_wdata      <= 32'h0c0c_3a3a;
    user_mode_flag <= 1'b0;
    @(posedge mclk);
    spr_write <= 1'b0;
    @(posedge mclk);
    spr_valid <= 1'b0;
    #1;
    chk(spr_rdata, 32'h0c0c_3a3a, "back to back read");
    chk(spr_done, 1'b1, "second done");
  endtask

  // zero contexts: write is dropped silently, reads give zero
  task automatic sc_context();
    acc(1'b1, sapsy_pkg::SPR_CONTEXT_CONTROL, 32'hffff_ffff, 1'b0);
    chk(got_ill | got_priv, 1'b0, "ctx write exc");
    chk(ctx_current, 4'h0, "ctx current");
    chk(csi_pending, 1'b1, "ctx write owes sync");
    acc(1'b0, sapsy_pkg::SPR_CONTEXT_CONTROL, 32'h0000_0000, 1'b0);
    chk(spr_rdata, 32'h0000_0000, "ctx read");
    acc(1'b0, sapsy_pkg::SPR_CONTEXT_CONTROL, 32'h0000_0000, 1'b1);
    chk(got_priv, 1'b1, "ctx user read");
  endtask

  // invalid numbers: response follows the privilege bit and the mode
  task automatic sc_invalid();
    logic [9:0] nums [6];
    logic       usrs [6];
    logic       pexp [6];
    nums = '{10'h100, 10'h100, 10'h008, 10'h030, 10'h030, 10'h3f0};
    usrs = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
    pexp = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    acc(1'b0, sapsy_pkg::SPR_CRIT_SAVE_1, 32'h0000_0000, 1'b0);
    for (int i = 0; i < 6; i++) begin
      acc(1'b0, nums[i], 32'h0000_0000, usrs[i]);
      chk(got_priv, pexp[i], "invalid priv");
      chk(got_ill, !pexp[i], "invalid illegal");
    end
    chk(spr_rdata, 32'h7ffe_a5c3, "refused read holds");
    acc(1'b1, sapsy_pkg::SPR_BRANCH_UNIT, 32'h1234_5678, 1'b1);
    chk(got_priv, 1'b1, "known reg in user");
    chk(branch_unit_ctrl_status, 32'h0000_0000, "user write dropped");
  endtask

  // every sync kind clears what a branch unit write owes
  task automatic sc_sync();
    for (int k = 0; k < sapsy_pkg::CSI_KINDS; k++) begin
      acc(1'b1, sapsy_pkg::SPR_BRANCH_UNIT, 32'ha5a5_0000 | 32'(k), 1'b0);
      chk(branch_unit_ctrl_status, 32'ha5a5_0000 | 32'(k), "branch reg");
      chk(csi_pending, 1'b1, "pending after write");
      @(posedge mclk);
      csi_event <= 5'(1 << k);
      @(posedge mclk);
      csi_event <= 5'h00;
      #1;
      chk(csi_pending, 1'b0, "pending cleared");
    end
    // cache-lock change with a sync in the same cycle: the new debt wins
    @(posedge mclk);
    user_cache_lock_enable_change <= 1'b1;
    csi_event   <= 5'h02;
    @(posedge mclk);
    user_cache_lock_enable_change <= 1'b0;
    csi_event   <= 5'h00;
    #1;
    chk(csi_pending, 1'b1, "set beats clear");
    @(posedge mclk);
    csi_event <= 5'h10;
    @(posedge mclk);
    csi_event <= 5'h00;
    #1;
    chk(csi_pending, 1'b0, "debug return clears");
  endtask

  // one sync operation pulse of the given kind
  task automatic pulse_csi(input int k);
    @(posedge mclk);
    csi_event <= 5'(1 << k);
    @(posedge mclk);
    csi_event <= 5'h00;
    #1;
  endtask

  // software duties around registers held elsewhere: here they are unknown
  // numbers with the privilege bit set, so a supervisor access is illegal
  task automatic sc_soft_sync();
    logic [9:0] nums [5];
    nums = '{10'h134, 10'h231, 10'h3f0, 10'h3f4, 10'h232};
    for (int i = 0; i < 5; i++) begin
      pulse_csi(sapsy_pkg::CSI_ISYNC);
      acc(1'b1, nums[i], 32'h0000_0001, 1'b0);
      chk(got_ill, 1'b1, "unheld number");
      chk(csi_pending, 1'b0, "refused write owes nothing");
      pulse_csi(sapsy_pkg::CSI_SYSCALL);
    end
    acc(1'b0, 10'h3f1, 32'h0000_0000, 1'b0);
    chk(got_ill, 1'b1, "config 1 read");
    chk(spr_rdata, 32'h7ffe_a5c3, "refused read keeps data");
  endtask

  // reset in mid-run brings outputs back to zero
  task automatic sc_reset();
    acc(1'b1, sapsy_pkg::SPR_BRANCH_UNIT, 32'hdead_0001, 1'b0);
    acc(1'b0, sapsy_pkg::SPR_BRANCH_UNIT, 32'h0000_0000, 1'b0);
    chk(spr_rdata, 32'hdead_0001, "branch read");
    @(posedge mclk);
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    #1;
    chk(branch_unit_ctrl_status, 32'h0000_0000, "reset branch");
    chk(csi_pending, 1'b0, "reset pending");
    chk(spr_rdata, 32'h0000_0000, "reset rdata");
    // first access after release: the save register lost its old value
    acc(1'b0, sapsy_pkg::SPR_CRIT_SAVE_0, 32'h0000_0000, 1'b0);
    chk(got_ill | got_priv, 1'b0, "access after reset");
    chk(spr_rdata, 32'h0000_0000, "reset save 0");
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    miscompares    = 0;
    n_tests        = 0;
    rstn           = 1'b0;
    spr_valid      = 1'b0;
    spr_write      = 1'b0;
    spr_num        = 10'h000;
    spr_wdata      = 32'h0000_0000;
    user_mode_flag = 1'b0;
    user_cache_lock_enable_change    = 1'b0;
    csi_event      = 5'h00;
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    sc_save_regs();
    sc_context();
    sc_invalid();
    sc_sync();
    sc_soft_sync();
    sc_reset();
    conclude();
  end

endmodule
